// *** logic/right_line_out_mixer_regs.v ***
// Purpose: register bank for the right line-output mixer and module power status
// Assumes: control port gives address, write strobe, read strobe, 8-bit data on core_clk
// Notes: power status inputs are async analog flags, synchronised before use
`include "rline_mix_map.vh"
module right_line_out_mixer_regs #(
	parameter STEP_CYCLES = (`STEP_NS + `CLK_NS - 1) / `CLK_NS
) (
	input wire core_clk,
	input wire rst_b,
	input wire [6:0] regAddr,
	input wire regWrite,
	input wire regRead,
	input wire [7:0] regWdata,
	output reg [7:0] regRdata,
	output reg regHit,
	input wire rightLineOutputPowered,
	input wire [6:0] modulePowered,
	output reg [5:0] routeEnable,
	output reg [41:0] appliedGain,
	output reg [3:0] rightLineOutputLevel,
	output reg rightLineOutputUnmute,
	output reg rsvdLevelBit
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function [2:0] srcIndex;
		input [6:0] a;
		begin
			srcIndex = a[2:0] + 3'h1;
		end
	endfunction

	function isSource;
		input [6:0] a;
		begin
			isSource = (a >= `OFS_SECOND_LINE_IN_LEFT_GAIN) && (a <= `OFS_RDAC_GAIN);
		end
	endfunction

	// codes above nine are reserved and never reach the analog level
	function levelLegal;
		input [3:0] code;
		begin
			levelLegal = (code <= `LEVEL_MAX);
		end
	endfunction

	function [7:0] levelStatus;
		input [3:0] lvl;
		input mt;
		input rs;
		input pd;
		input pw;
		begin
			levelStatus = {lvl, mt, rs, pd, pw};
		end
	endfunction

	// ----------------------------------------
	// storage
	// ----------------------------------------
	reg [7:0] srcReg [0:5];
	reg [3:0] level;
	reg mute;
	reg rsvd;
	reg pwrMeta;
	reg pwrSync;
	reg [6:0] modMeta;
	reg [6:0] modSync;
	wire [5:0] pend;
	wire [41:0] applied;
	wire anyPending;
	integer i;
	reg [5:0] next_srcWe;
	reg [3:0] next_level;
	reg next_mute;
	reg next_rsvd;
	reg [7:0] next_regRdata;
	reg next_regHit;
	wire [2:0] selIdx;
	wire addrSrc;
	wire addrLevel;
	wire addrPower;
	wire addrMapped;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	assign addrSrc = isSource(regAddr);
	assign addrLevel = (regAddr == `OFS_OUT_LEVEL);
	assign addrPower = (regAddr == `OFS_PWR_STATUS);
	assign addrMapped = addrSrc || addrLevel || addrPower;
	// only meaningful while addrSrc is high
	assign selIdx = srcIndex(regAddr);

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	always @* begin
		next_srcWe = 6'h00;
		next_level = level;
		next_mute = mute;
		next_rsvd = rsvd;
		if (regWrite) begin
			if (addrSrc) begin
				next_srcWe[selIdx] = 1'b1;
			end else if (addrLevel) begin
				// reserved codes keep the previous level
				if (levelLegal(regWdata[`LEVEL_MSB:`LEVEL_LSB]))
					next_level = regWdata[`LEVEL_MSB:`LEVEL_LSB];
				next_mute = regWdata[`MUTE_BIT];
				next_rsvd = regWdata[`RSVD_BIT];
			end
			// status bits and power status have no storage to write
		end
	end

	// ----------------------------------------
	// read decode
	// ----------------------------------------
	always @* begin
		next_regRdata = regRdata;
		next_regHit = 1'b0;
		if (regRead) begin
			next_regHit = addrMapped;
			if (addrSrc)
				next_regRdata = srcReg[selIdx];
			else if (addrLevel)
				next_regRdata = levelStatus(level, mute, rsvd, anyPending, pwrSync);
			else if (addrPower)
				// bit 0 has no source, reads zero
				next_regRdata = {modSync, 1'b0};
			else
				next_regRdata = 8'h00;
		end
	end

	// ----------------------------------------
	// status synchronisers
	// ----------------------------------------
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pwrMeta <= 1'b0;
			pwrSync <= 1'b0;
			modMeta <= 7'h00;
			modSync <= 7'h00;
		end else begin
			pwrMeta <= rightLineOutputPowered;
			pwrSync <= pwrMeta;
			modMeta <= modulePowered;
			modSync <= modMeta;
		end
	end

	// ----------------------------------------
	// writes
	// ----------------------------------------
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (i = 0; i < 6; i = i + 1)
				srcReg[i] <= `GAIN_RESET;
			level <= `LEVEL_RESET;
			mute <= 1'b0;
			rsvd <= 1'b0;
		end else begin
			for (i = 0; i < 6; i = i + 1)
				if (next_srcWe[i])
					srcReg[i] <= regWdata;
			level <= next_level;
			mute <= next_mute;
			rsvd <= next_rsvd;
		end
	end

	// ----------------------------------------
	// gain ramping, one stepper per source
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : ramp
			gain_stepper #(
				.STEP_CYCLES(STEP_CYCLES)
			) stepper (
				.core_clk(core_clk),
				.rst_b(rst_b),
				.target(srcReg[g][`GAIN_MSB:0]),
				.applied(applied[g*7 +: 7]),
				.pending(pend[g])
			);
		end
	endgenerate

	// pending while any gain still ramps
	assign anyPending = |pend;

	// ----------------------------------------
	// outputs and read data
	// ----------------------------------------
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			regRdata <= 8'h00;
			regHit <= 1'b0;
			routeEnable <= 6'h00;
			appliedGain <= 42'h000_0000_0000;
			rightLineOutputLevel <= `LEVEL_RESET;
			rightLineOutputUnmute <= 1'b0;
			rsvdLevelBit <= 1'b0;
		end else begin
			for (i = 0; i < 6; i = i + 1)
				routeEnable[i] <= srcReg[i][`ROUTE_BIT];
			appliedGain <= applied;
			rightLineOutputLevel <= level;
			rightLineOutputUnmute <= mute;
			rsvdLevelBit <= rsvd;
			// read data holds until the next read
			regHit <= next_regHit;
			regRdata <= next_regRdata;
		end
	end
endmodule

// *** logic/rline_mix_map.vh ***
// Purpose: offsets, field positions, reset values for the right line-output mixer registers
// Assumes: 7-bit register address, 8-bit data, one register per address
// Notes: gain code meaning lives in the analog block
`ifndef RLINE_MIX_MAP_VH
`define RLINE_MIX_MAP_VH

// ----------------------------------------
// offsets
// ----------------------------------------
`define OFS_SECOND_LINE_IN_LEFT_GAIN 7'h57
`define OFS_LPRE_GAIN 7'h58
`define OFS_LDAC_GAIN 7'h59
`define OFS_SECOND_LINE_IN_RIGHT_GAIN 7'h5A
`define OFS_RPRE_GAIN 7'h5B
`define OFS_RDAC_GAIN 7'h5C
`define OFS_OUT_LEVEL 7'h5D
`define OFS_PWR_STATUS 7'h5E

// ----------------------------------------
// fields
// ----------------------------------------
`define ROUTE_BIT 7
`define GAIN_MSB 6
`define LEVEL_MSB 7
`define LEVEL_LSB 4
`define MUTE_BIT 3
`define RSVD_BIT 2
`define PENDING_BIT 1
`define POWERED_BIT 0
`define LEVEL_MAX 4'h9

// ----------------------------------------
// reset values
// ----------------------------------------
`define GAIN_RESET 8'h00
`define LEVEL_RESET 4'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define STEP_NS 1000
`define CLK_NS 10

`endif

// *** logic/gain_stepper.v ***
// Purpose: walks one applied gain code toward its programmed target
// Assumes: target from the register file, same clock
// Notes: one code step per step period; pending while applied differs from target
`include "rline_mix_map.vh"
module gain_stepper #(
	parameter STEP_CYCLES = (`STEP_NS + `CLK_NS - 1) / `CLK_NS
) (
	input wire core_clk,
	input wire rst_b,
	input wire [6:0] target,
	output reg [6:0] applied,
	output reg pending
);
	reg [15:0] tick;
	wire stepNow;

	assign stepNow = (tick == STEP_CYCLES[15:0] - 16'h0001);

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tick <= 16'h0000;
			applied <= 7'h00;
			pending <= 1'b0;
		end else begin
			tick <= stepNow ? 16'h0000 : tick + 16'h0001;
			if (stepNow && applied != target)
				applied <= (applied < target) ? applied + 7'h01 : applied - 7'h01;
			pending <= (applied != target);
		end
	end
endmodule

// *** tb/rline_mix_sva.sv ***
// Purpose: port checks for the right line-out mixer bank
// Assumes: one clock domain, reset low
// Notes: gain ramp timing is left to the bench
module rline_mix_sva (
	input logic core_clk,
	input logic rst_b,
	input logic [6:0] regAddr,
	input logic regWrite,
	input logic regRead,
	input logic [7:0] regWdata,
	input logic [7:0] regRdata,
	input logic regHit,
	input logic [5:0] routeEnable,
	input logic [3:0] rightLineOutputLevel,
	input logic rightLineOutputUnmute
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	wire lvlWr = regWrite && regAddr == 7'h5D;
	wire srcWr = regWrite && regAddr == 7'h57;
	wire mapped = regAddr >= 7'h57 && regAddr <= 7'h5E;
	property p_rst; $rose(rst_b) |-> !routeEnable && !rightLineOutputLevel; endproperty
	a_rst: assert property (p_rst) else $error("reset");
	property p_route; srcWr ##1 !srcWr |=> routeEnable[0] == $past(regWdata[7], 2); endproperty
	a_route: assert property (p_route) else $error("route");
	property p_lvl; lvlWr && regWdata[7:4] <= 4'h9 ##1 !lvlWr |=> rightLineOutputLevel == $past(regWdata[7:4], 2); endproperty
	a_lvl: assert property (p_lvl) else $error("level");
	property p_rej; lvlWr && regWdata[7:4] > 4'h9 ##1 !lvlWr |=> $stable(rightLineOutputLevel); endproperty
	a_rej: assert property (p_rej) else $error("reserved level");
	property p_mute; lvlWr ##1 !lvlWr |=> rightLineOutputUnmute == $past(regWdata[3], 2); endproperty
	a_mute: assert property (p_mute) else $error("mute");
	property p_rdlvl; regRead && regAddr == 7'h5D |=> regRdata[7:3] == {rightLineOutputLevel, rightLineOutputUnmute}; endproperty
	a_rdlvl: assert property (p_rdlvl) else $error("level read");
	property p_hit; regRead |=> regHit == $past(mapped) && (regHit || regRdata == 8'h00); endproperty
	a_hit: assert property (p_hit) else $error("hit");
	property p_hold; !regRead |=> $stable(regRdata); endproperty
	a_hold: assert property (p_hold) else $error("hold");
endmodule
bind right_line_out_mixer_regs rline_mix_sva chk (.core_clk, .rst_b, .regAddr, .regWrite, .regRead, .regWdata,
	.regRdata, .regHit, .routeEnable, .rightLineOutputLevel, .rightLineOutputUnmute);

// *** tb/tb_top.sv ***
// Purpose: self-checking bench of the right line-out mixer bank
// Assumes: two cycles per gain code step
// Notes: gains start at 0x40 or more so pending is caught
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, rst_b = 0, regWrite = 0, regRead = 0, rightLineOutputPowered = 0;
	logic regHit, rightLineOutputUnmute, rsvdLevelBit;
	logic [6:0] regAddr = 0, modulePowered = 0;
	logic [7:0] regWdata = 0, regRdata, g [6];
	logic [5:0] routeEnable;
	logic [41:0] appliedGain;
	logic [3:0] rightLineOutputLevel, lvl;
	int num_errors = 0, tests_run = 0, seed = 37, cyc = 0;
	always #5 core_clk = ~core_clk;
	right_line_out_mixer_regs #(.STEP_CYCLES(2)) dut (.core_clk, .rst_b, .regAddr, .regWrite, .regRead, .regWdata,
		.regRdata, .regHit, .rightLineOutputPowered, .modulePowered, .routeEnable, .appliedGain,
		.rightLineOutputLevel, .rightLineOutputUnmute, .rsvdLevelBit);
	function logic [3:0] expLvl(logic [3:0] old, logic [3:0] code);
		return code <= 4'h9 ? code : old;
	endfunction
	task chk(string what, logic [8:0] exp, logic [8:0] seen);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// reads carry the expected byte in d
	task bus(logic w, logic [6:0] a, logic [7:0] d, logic hit = 1);
		@(posedge core_clk);
		regWrite <= w;
		regRead <= !w;
		regAddr <= a;
		regWdata <= d;
		@(posedge core_clk);
		regWrite <= 1'h0;
		regRead <= 1'h0;
		@(negedge core_clk);
		if (!w)
			chk("read", {hit, d}, {regHit, regRdata});
	endtask
	task summarize();
		$display("runs %0d errs %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc > 5000) begin
			num_errors++;
			summarize();
		end
	end
	initial begin
		repeat (6) @(posedge core_clk);
		rst_b <= 1'h1;
		for (int i = 0; i < 8; i++)
			bus(0, 7'h57 + 7'(i), 8'h00);
		$display("rst done");
		for (int i = 0; i < 6; i++) begin
			g[i] = 8'($random(seed)) | 8'h40;
			bus(1, 7'h57 + 7'(i), g[i]);
		end
		bus(0, 7'h5D, 8'h02);
		// longest ramp is 127 codes of two cycles
		repeat (300) @(posedge core_clk);
		bus(0, 7'h5D, 8'h00);
		for (int i = 0; i < 6; i++) begin
			bus(0, 7'h57 + 7'(i), g[i]);
			chk("route", {8'h00, g[i][7]}, {8'h00, routeEnable[i]});
			chk("gain", {2'h0, g[i][6:0]}, {2'h0, appliedGain[i*7 +: 7]});
		end
		$display("gain done");
		lvl = 4'h0;
		for (int c = 0; c < 16; c++) begin
			bus(1, 7'h5D, {c[3:0], c[0], 3'b011});
			lvl = expLvl(lvl, c[3:0]);
			bus(0, 7'h5D, {lvl, c[0], 3'b000});
			chk("level out", {5'h00, lvl}, {5'h00, rightLineOutputLevel});
			chk("unmute", {8'h00, c[0]}, {8'h00, rightLineOutputUnmute});
			chk("rsvd out", 9'h000, {8'h00, rsvdLevelBit});
		end
		$display("lvl done");
		@(posedge core_clk);
		modulePowered <= 7'($random(seed));
		rightLineOutputPowered <= 1'h1;
		repeat (4) @(posedge core_clk);
		bus(1, 7'h5E, 8'h00);
		bus(0, 7'h5E, {modulePowered, 1'h0});
		bus(0, 7'h5D, {lvl, 4'h9});
		bus(0, 7'h10, 8'h00, 1'h0);
		$display("pwr done");
		summarize();
	end
endmodule
